// ===== calib_vector_and_trim_regs_tb.sv
// self-checking bench for the calibration vector port and trim registers
`timescale 1ns/1ps
module calib_vector_and_trim_regs_tb;
  import cvt_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [CVT_ADDR_W-1:0] paddr = '0;
  logic [CVT_DATA_W-1:0] pwdata = '0;
  logic [CVT_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic halted = 1'b0;
  logic [7:0] fuse_a = 8'hA5;
  logic [7:0] fuse_b = 8'h3C;
  logic [3:0] fuse_ref = 4'h9;
  logic [7:0] gain_a;
  logic [7:0] gain_b;
  logic [3:0] ref_adj;
  logic vec_valid;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;
  int waits;

  always #50 clk = ~clk;

  cvt_regs dut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .APB_PSEL_IN(psel), .APB_PENABLE_IN(penable),
    .APB_PWRITE_IN(pwrite), .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata), .APB_PRDATA_OUT(prdata),
    .APB_PREADY_OUT(pready), .APB_PSLVERR_OUT(pslverr), .CALIB_HALTED_FLAG_IN(halted),
    .FUSE_GAIN_A_IN(fuse_a), .FUSE_GAIN_B_IN(fuse_b), .FUSE_REF_ADJUST_IN(fuse_ref),
    .GAIN_ADJUST_A_OUT(gain_a), .GAIN_ADJUST_B_OUT(gain_b), .REFERENCE_ADJUST_OUT(ref_adj),
    .VECTOR_VALID_OUT(vec_valid));

  function automatic logic [CVT_ADDR_W-1:0] ad(input logic [7:0] idx);
    ad = {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [7:0] pat(input int i);
    pat = 8'(i * 7 + 3);
  endfunction

  // one apb transfer, entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    waits = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad(idx);
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // ready is judged mid-cycle, where it has settled, and the next rising edge takes the transfer
    @(negedge clk);
    while (pready !== 1'b1) begin
      waits++;
      @(negedge clk);
    end
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
    chk({what, " error"}, {31'h0, experr}, {31'h0, err});
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end

  initial begin
    int i;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("gain a out", 32'(8'hA5), 32'(gain_a)); // fuse load
    chk("gain b out", 32'(8'h3C), 32'(gain_b)); // fuse load
    chk("ref out", 32'(4'h9), 32'(ref_adj)); // fuse load
    rchk("gain a", CVT_IDX_GAIN_A, 32'h0000_00A5, 1'b0); // readable
    rchk("gain b", CVT_IDX_GAIN_B, 32'h0000_003C, 1'b0); // readable
    rchk("ref", CVT_IDX_REF_ADJ, 32'h0000_0009, 1'b0); // readable
    rchk("port enable", CVT_IDX_PORT_EN, 32'h0, 1'b0); // reset value
    rchk("vector disabled", CVT_IDX_VEC_PORT, 32'h0, 1'b1); // refused
    rchk("unmapped", 8'h72, 32'h0, 1'b1);
    $display("test reset and refusal done");
    apb(1'b1, CVT_IDX_GAIN_A, 32'h0000_0011);
    apb(1'b1, CVT_IDX_GAIN_B, 32'h0000_00EE);
    apb(1'b1, CVT_IDX_REF_ADJ, 32'h0000_00FF);
    rchk("gain a wr", CVT_IDX_GAIN_A, 32'h0000_0011, 1'b0); // modify
    rchk("gain b wr", CVT_IDX_GAIN_B, 32'h0000_00EE, 1'b0); // modify
    rchk("ref wr", CVT_IDX_REF_ADJ, 32'h0000_000F, 1'b0); // reserved bits
    chk("trim outs", 32'h0011_EE0F, {8'h0, gain_a, gain_b, 4'h0, ref_adj}); // outputs
    $display("test trims done");
    // halted held high before any vector access
    halted <= 1'b1;
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0001);
    for (i = 0; i < CVT_VEC_LEN; i++) begin
      apb(1'b1, CVT_IDX_VEC_PORT, {24'h0, pat(i)});
      chk("restore wait", 32'd1, 32'(waits)); // freeze off
      chk("restore error", 32'h0, {31'h0, err});
    end
    chk("valid after restore", 32'h1, {31'h0, vec_valid});
    rchk("status", CVT_IDX_STREAM_CTRL, 32'h0000_0006, 1'b0);
    $display("test restore done");
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0000);
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0001);
    apb(1'b1, CVT_IDX_STREAM_CTRL, 32'h0000_0001);
    for (i = 0; i < CVT_VEC_LEN; i++) begin
      apb(1'b0, CVT_IDX_VEC_PORT, 32'h0);
      chk("readout", {24'h0, pat(i)}, rd);
      chk("stream wait", 32'd0, 32'(waits)); // freeze on
    end
    chk("valid after readout", 32'h1, {31'h0, vec_valid});
    $display("test readout done");
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0000);
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      rchk("restart", CVT_IDX_VEC_PORT, {24'h0, pat(i)}, 1'b0); // restart
    end
    chk("valid mid sequence", 32'h0, {31'h0, vec_valid}); // started
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0000);
    chk("valid after abort", 32'h0, {31'h0, vec_valid}); // abort
    rchk("vector after disable", CVT_IDX_VEC_PORT, 32'h0, 1'b1); // disabled again
    $display("test abort done");
    // one access made while calibration runs must spoil an otherwise full pass
    halted <= 1'b0;
    apb(1'b1, CVT_IDX_PORT_EN, 32'h0000_0001);
    for (i = 0; i < CVT_VEC_LEN; i++) begin
      apb(1'b0, CVT_IDX_VEC_PORT, 32'h0);
      halted <= 1'b1;
    end
    chk("valid after running access", 32'h0, {31'h0, vec_valid});
    $display("test spoiled pass done");
    summarize();
  end
endmodule

// ===== cvt_pkg.sv
// shared constants for the calibration vector and trim register bank
package cvt_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] CVT_IDX_PORT_EN = 8'h70;
  localparam logic [7:0] CVT_IDX_VEC_PORT = 8'h71;
  localparam logic [7:0] CVT_IDX_STREAM_CTRL = 8'h77;
  localparam logic [7:0] CVT_IDX_GAIN_A = 8'h7A;
  localparam logic [7:0] CVT_IDX_GAIN_B = 8'h7B;
  localparam logic [7:0] CVT_IDX_REF_ADJ = 8'h7C;

  localparam int CVT_ADDR_W = 12;
  localparam int CVT_DATA_W = 32;

  // field positions
  localparam int CVT_PORT_EN_BIT = 0;
  localparam int CVT_FREEZE_BIT = 0;
  localparam int CVT_HALTED_BIT = 1;
  localparam int CVT_VALID_BIT = 2;
  localparam int CVT_REF_W = 4;

  // reset values
  localparam logic [7:0] CVT_PORT_EN_RST = 8'h00;
  localparam logic CVT_FREEZE_RST = 1'b0;

  // calibration vector length and index
  localparam int CVT_VEC_LEN = 673;
  localparam int CVT_IDX_W = 10;
  localparam logic [CVT_IDX_W-1:0] CVT_IDX_FIRST = 10'h000;
  localparam logic [CVT_IDX_W-1:0] CVT_IDX_LAST = 10'(CVT_VEC_LEN - 1);

  // byte address of a register index
  function automatic logic [CVT_ADDR_W-1:0] cvt_byte_addr(input logic [7:0] idx);
    cvt_byte_addr = {2'h0, idx, 2'h0};
  endfunction

  // next vector index with wrap to the first entry
  function automatic logic [CVT_IDX_W-1:0] cvt_idx_step(input logic [CVT_IDX_W-1:0] idx);
    cvt_idx_step = (idx == CVT_IDX_LAST) ? CVT_IDX_FIRST : idx + 10'h001;
  endfunction
endpackage

// ===== cvt_regs.sv
// calibration vector port and trim registers behind an APB slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - vector port works only while bit 0 of the port enable register is set
// - successive vector port reads return successive calibration entries, 673 in all
// - successive vector port writes load successive calibration entries, 673 in all
// - with address freeze set, vector port accesses stream without a wait state
// - a sequence ending before 673 accesses leaves the vector marked invalid
// - input a gain trim loads its factory value at reset, then read-write
// - input b gain trim loads its factory value at reset, then read-write
// - reference trim holds 4 bits from factory at reset; bits 7:4 reserved
module cvt_regs
  import cvt_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic APB_PSEL_IN,
  input wire logic APB_PENABLE_IN,
  input wire logic APB_PWRITE_IN,
  input wire logic [CVT_ADDR_W-1:0] APB_PADDR_IN,
  input wire logic [CVT_DATA_W-1:0] APB_PWDATA_IN,
  output logic [CVT_DATA_W-1:0] APB_PRDATA_OUT,
  output logic APB_PREADY_OUT,
  output logic APB_PSLVERR_OUT,
  input wire logic CALIB_HALTED_FLAG_IN,
  input wire logic [7:0] FUSE_GAIN_A_IN,
  input wire logic [7:0] FUSE_GAIN_B_IN,
  input wire logic [CVT_REF_W-1:0] FUSE_REF_ADJUST_IN,
  output logic [7:0] GAIN_ADJUST_A_OUT,
  output logic [7:0] GAIN_ADJUST_B_OUT,
  output logic [CVT_REF_W-1:0] REFERENCE_ADJUST_OUT,
  output logic VECTOR_VALID_OUT
);
  logic [7:0] port_en_reg;
  logic [7:0] port_en_next;
  logic freeze_reg;
  logic freeze_next;
  logic [7:0] gain_a_reg;
  logic [7:0] gain_a_next;
  logic [7:0] gain_b_reg;
  logic [7:0] gain_b_next;
  logic [CVT_REF_W-1:0] ref_reg;
  logic [CVT_REF_W-1:0] ref_next;
  logic [CVT_IDX_W-1:0] index_reg;
  logic [CVT_IDX_W-1:0] index_next;
  logic valid_reg;
  logic valid_next;
  logic bad_reg;
  logic bad_next;
  logic wait_reg;
  logic wait_next;
  logic [CVT_DATA_W-1:0] prdata_reg;
  logic [CVT_DATA_W-1:0] prdata_next;
  logic err_reg;
  logic err_next;

  // address decode
  wire addr_aligned = (APB_PADDR_IN[1:0] == 2'h0) && (APB_PADDR_IN[CVT_ADDR_W-1:10] == 2'h0);
  wire hit_en = addr_aligned && (APB_PADDR_IN == cvt_byte_addr(CVT_IDX_PORT_EN));
  wire hit_vec = addr_aligned && (APB_PADDR_IN == cvt_byte_addr(CVT_IDX_VEC_PORT));
  wire hit_ctrl = addr_aligned && (APB_PADDR_IN == cvt_byte_addr(CVT_IDX_STREAM_CTRL));
  wire hit_ga = addr_aligned && (APB_PADDR_IN == cvt_byte_addr(CVT_IDX_GAIN_A));
  wire hit_gb = addr_aligned && (APB_PADDR_IN == cvt_byte_addr(CVT_IDX_GAIN_B));
  wire hit_ref = addr_aligned && (APB_PADDR_IN == cvt_byte_addr(CVT_IDX_REF_ADJ));
  wire hit_any = hit_en || hit_vec || hit_ctrl || hit_ga || hit_gb || hit_ref;

  wire port_open = port_en_reg[CVT_PORT_EN_BIT];
  wire setup_phase = APB_PSEL_IN && !APB_PENABLE_IN;
  wire access_phase = APB_PSEL_IN && APB_PENABLE_IN;
  wire done = access_phase && APB_PREADY_OUT;
  wire wr_done = done && APB_PWRITE_IN;

  wire vec_refused = hit_vec && !port_open;
  wire vec_done = done && hit_vec && port_open;
  wire vec_wr = vec_done && APB_PWRITE_IN;

  // freeze removes the wait state on the vector port
  assign APB_PREADY_OUT = !(hit_vec && port_open) || freeze_reg || wait_reg;
  assign APB_PRDATA_OUT = prdata_reg;
  assign APB_PSLVERR_OUT = err_reg && access_phase;

  wire [7:0] vec_rdata;

  // storage addressed by the running index
  cvt_vector_store u_store (
    .clk_in(SYS_CLK_IN),
    .wr_en_in(vec_wr),
    .index_in(index_reg),
    .wdata_in(APB_PWDATA_IN[7:0]),
    .rdata_out(vec_rdata)
  );

  wire en_write = wr_done && hit_en;
  wire en_new = APB_PWDATA_IN[CVT_PORT_EN_BIT];
  // enable edges seen on register writes
  wire en_rise = en_write && en_new && !port_open;
  wire en_fall = en_write && !en_new && port_open;

  wire [7:0] status_byte = {5'h00, valid_reg, CALIB_HALTED_FLAG_IN, freeze_reg};

  // read data picked during setup so it stands through the access phase
  wire [7:0] rd_byte =
    hit_en ? port_en_reg :
    hit_vec ? (port_open ? vec_rdata : 8'h00) :
    hit_ctrl ? status_byte :
    hit_ga ? gain_a_reg :
    hit_gb ? gain_b_reg :
    hit_ref ? {4'h0, ref_reg} : 8'h00;

  always_comb begin
    port_en_next = port_en_reg;
    freeze_next = freeze_reg;
    gain_a_next = gain_a_reg;
    gain_b_next = gain_b_reg;
    ref_next = ref_reg;
    if (wr_done && hit_en) begin
      port_en_next = APB_PWDATA_IN[7:0];
    end
    if (wr_done && hit_ctrl) begin
      freeze_next = APB_PWDATA_IN[CVT_FREEZE_BIT];
    end
    if (wr_done && hit_ga) begin
      gain_a_next = APB_PWDATA_IN[7:0];
    end
    if (wr_done && hit_gb) begin
      gain_b_next = APB_PWDATA_IN[7:0];
    end
    // only the low nibble is stored
    if (wr_done && hit_ref) begin
      ref_next = APB_PWDATA_IN[CVT_REF_W-1:0];
    end
  end

  always_comb begin
    index_next = index_reg;
    valid_next = valid_reg;
    bad_next = bad_reg;
    // restart on a fresh enable, forget a half sequence on disable
    if (en_rise || en_fall) begin
      index_next = CVT_IDX_FIRST;
    end else if (vec_done) begin
      index_next = cvt_idx_step(index_reg);
    end
    // a sequence in flight leaves the vector invalid
    if (en_fall && index_reg != CVT_IDX_FIRST) begin
      valid_next = 1'b0;
    end
    if (vec_done) begin
      if (index_reg == CVT_IDX_FIRST) begin
        valid_next = 1'b0;
        bad_next = 1'b0;
      end
      // an access while running spoils the whole sequence
      if (!CALIB_HALTED_FLAG_IN) begin
        bad_next = 1'b1;
      end
      // only a full pass without faults makes the vector valid
      if (index_reg == CVT_IDX_LAST) begin
        valid_next = !(bad_reg || !CALIB_HALTED_FLAG_IN);
      end
    end
  end

  always_comb begin
    wait_next = 1'b0;
    if (access_phase && !APB_PREADY_OUT) begin
      wait_next = 1'b1;
    end
    prdata_next = prdata_reg;
    err_next = err_reg;
    if (setup_phase) begin
      prdata_next = {24'h000000, rd_byte};
      err_next = !hit_any || vec_refused;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      port_en_reg <= CVT_PORT_EN_RST;
      freeze_reg <= CVT_FREEZE_RST;
      // factory values are taken while reset is held
      gain_a_reg <= FUSE_GAIN_A_IN;
      gain_b_reg <= FUSE_GAIN_B_IN;
      ref_reg <= FUSE_REF_ADJUST_IN;
      index_reg <= CVT_IDX_FIRST;
      valid_reg <= 1'b0;
      bad_reg <= 1'b0;
      wait_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else begin
      port_en_reg <= port_en_next;
      freeze_reg <= freeze_next;
      gain_a_reg <= gain_a_next;
      gain_b_reg <= gain_b_next;
      ref_reg <= ref_next;
      index_reg <= index_next;
      valid_reg <= valid_next;
      bad_reg <= bad_next;
      wait_reg <= wait_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign GAIN_ADJUST_A_OUT = gain_a_reg;
  assign GAIN_ADJUST_B_OUT = gain_b_reg;
  assign REFERENCE_ADJUST_OUT = ref_reg;
  assign VECTOR_VALID_OUT = valid_reg;

  // checks
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking

  sequence s_vec_setup;
    setup_phase && hit_vec && port_open;
  endsequence

  sequence s_one_wait;
    (access_phase && !APB_PREADY_OUT) ##1 (access_phase && APB_PREADY_OUT);
  endsequence

  sequence s_refused_setup;
    setup_phase && vec_refused;
  endsequence

  a_port_gated_off: assert property (disable iff (!NRST_IN)
    (done && hit_vec && !port_open && !en_rise) |=> (index_reg == $past(index_reg)) && !$past(vec_wr))
    else $error("vector index moved while port disabled");

  a_index_step_up: assert property (disable iff (!NRST_IN)
    (vec_done && index_reg != CVT_IDX_LAST) |=> index_reg == $past(index_reg) + 10'h001)
    else $error("vector index did not advance by one");

  a_read_data_entry: assert property (disable iff (!NRST_IN)
    (s_vec_setup and !APB_PWRITE_IN) |=> APB_PRDATA_OUT == {24'h000000, $past(vec_rdata)})
    else $error("vector read data not the current entry");

  a_write_loads_entry: assert property (disable iff (!NRST_IN)
    (vec_wr && index_reg != CVT_IDX_LAST) |=> u_store.mem_reg[$past(index_reg)] == $past(APB_PWDATA_IN[7:0]))
    else $error("vector write not stored at index");

  a_freeze_no_wait: assert property (disable iff (!NRST_IN)
    (s_vec_setup and freeze_reg) |=> APB_PREADY_OUT)
    else $error("frozen vector access was stalled");

  a_plain_one_wait: assert property (disable iff (!NRST_IN)
    (s_vec_setup and !freeze_reg) |=> s_one_wait)
    else $error("unfrozen vector access not one wait state");

  a_early_end_bad: assert property (disable iff (!NRST_IN)
    (en_fall && index_reg != CVT_IDX_FIRST) |=> !VECTOR_VALID_OUT && index_reg == CVT_IDX_FIRST)
    else $error("aborted sequence left vector valid");

  a_full_pass_valid: assert property (disable iff (!NRST_IN)
    (vec_done && index_reg == CVT_IDX_LAST && !bad_reg && CALIB_HALTED_FLAG_IN)
    |=> VECTOR_VALID_OUT && index_reg == CVT_IDX_FIRST)
    else $error("complete sequence did not validate vector");

  a_gain_a_fuse: assert property (
    !NRST_IN |=> GAIN_ADJUST_A_OUT == $past(FUSE_GAIN_A_IN))
    else $error("gain a did not load factory value");

  a_gain_b_fuse: assert property (
    !NRST_IN |=> GAIN_ADJUST_B_OUT == $past(FUSE_GAIN_B_IN))
    else $error("gain b did not load factory value");

  a_ref_reserved_zero: assert property (disable iff (!NRST_IN)
    (setup_phase && hit_ref) |=> APB_PRDATA_OUT[7:CVT_REF_W] == 4'h0 &&
    APB_PRDATA_OUT[CVT_REF_W-1:0] == $past(ref_reg))
    else $error("reference trim read wrong");

  a_enable_restart: assert property (disable iff (!NRST_IN)
    en_rise |=> index_reg == CVT_IDX_FIRST && port_open)
    else $error("fresh enable did not restart index");

  a_index_hold: assert property (disable iff (!NRST_IN)
    (!vec_done && !en_rise && !en_fall) |=> $stable(index_reg))
    else $error("vector index moved without access");

  a_refused_no_wait: assert property (disable iff (!NRST_IN)
    s_refused_setup |=> APB_PREADY_OUT)
    else $error("refused vector access was stalled");

  a_refused_error: assert property (disable iff (!NRST_IN)
    (s_refused_setup ##1 access_phase) |-> APB_PSLVERR_OUT && APB_PRDATA_OUT == 32'h00000000)
    else $error("refused vector access not flagged");

  a_enable_write: assert property (disable iff (!NRST_IN)
    en_write |=> port_en_reg == $past(APB_PWDATA_IN[7:0]))
    else $error("port enable write not stored");

  a_enable_read: assert property (disable iff (!NRST_IN)
    (setup_phase && hit_en) |=> APB_PRDATA_OUT == {24'h000000, $past(port_en_reg)})
    else $error("port enable read wrong");

  a_index_wrap: assert property (disable iff (!NRST_IN)
    (vec_done && index_reg == CVT_IDX_LAST) |=> index_reg == CVT_IDX_FIRST)
    else $error("vector index did not wrap");

  a_freeze_write: assert property (disable iff (!NRST_IN)
    (wr_done && hit_ctrl) |=> freeze_reg == $past(APB_PWDATA_IN[CVT_FREEZE_BIT]))
    else $error("address freeze write not stored");

  a_status_read: assert property (disable iff (!NRST_IN)
    (setup_phase && hit_ctrl) |=>
    APB_PRDATA_OUT == {29'h0000000, $past(valid_reg), $past(CALIB_HALTED_FLAG_IN), $past(freeze_reg)})
    else $error("status read wrong");

  a_halted_spoils: assert property (disable iff (!NRST_IN)
    (vec_done && index_reg == CVT_IDX_LAST && (bad_reg || !CALIB_HALTED_FLAG_IN)) |=> !VECTOR_VALID_OUT)
    else $error("spoiled sequence validated vector");

  a_first_clears_valid: assert property (disable iff (!NRST_IN)
    (vec_done && index_reg == CVT_IDX_FIRST) |=> !VECTOR_VALID_OUT)
    else $error("new sequence kept vector valid");

  a_valid_holds: assert property (disable iff (!NRST_IN)
    (!vec_done && !en_fall) |=> $stable(VECTOR_VALID_OUT))
    else $error("vector valid changed without access");

  a_gain_a_write: assert property (disable iff (!NRST_IN)
    (wr_done && hit_ga) |=> GAIN_ADJUST_A_OUT == $past(APB_PWDATA_IN[7:0]))
    else $error("gain a write not stored");

  a_gain_a_read: assert property (disable iff (!NRST_IN)
    (setup_phase && hit_ga) |=> APB_PRDATA_OUT == {24'h000000, $past(gain_a_reg)})
    else $error("gain a read wrong");

  a_gain_b_write: assert property (disable iff (!NRST_IN)
    (wr_done && hit_gb) |=> GAIN_ADJUST_B_OUT == $past(APB_PWDATA_IN[7:0]))
    else $error("gain b write not stored");

  a_gain_b_read: assert property (disable iff (!NRST_IN)
    (setup_phase && hit_gb) |=> APB_PRDATA_OUT == {24'h000000, $past(gain_b_reg)})
    else $error("gain b read wrong");

  a_ref_write: assert property (disable iff (!NRST_IN)
    (wr_done && hit_ref) |=> REFERENCE_ADJUST_OUT == $past(APB_PWDATA_IN[CVT_REF_W-1:0]))
    else $error("reference trim write not stored");

  a_trims_hold: assert property (disable iff (!NRST_IN)
    !(wr_done && (hit_ga || hit_gb || hit_ref)) |=>
    $stable(GAIN_ADJUST_A_OUT) && $stable(GAIN_ADJUST_B_OUT) && $stable(REFERENCE_ADJUST_OUT))
    else $error("trim changed without a write");
endmodule

// ===== cvt_vector_store.sv
// calibration vector storage, one byte per entry, addressed by index
`timescale 1ns/1ps
module cvt_vector_store
  import cvt_pkg::*;
(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [CVT_IDX_W-1:0] index_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem_reg [CVT_VEC_LEN];

  // contents are data only; their validity is tracked by the register bank
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[index_in] <= wdata_in;
    end
  end

  assign rdata_out = mem_reg[index_in];
endmodule
